// ===== core/vic_cmd_regs.v
// Purpose: command/status part of a 32-source vectored interrupt controller
// Assumes: APB slave on pclk; source lines are asynchronous, rising edge marks an event
// Notes:   lowest-numbered enabled source of 1-31 not routed to fast wins the normal line; no nesting of normal interrupts
`timescale 1ns/100ps
`include "vic_regs.vh"
`default_nettype none

module vic_cmd_regs
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // interrupt sources, asynchronous
    input  wire [31:0] source_in,
    // processor request lines, active low
    output reg         normal_request_output_n,
    output reg         fast_request_output_n
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [31:0] src_meta;
    reg  [31:0] src_sync;
    reg  [31:0] src_prev;
    reg  [31:0] pending;
    reg  [31:0] enable_state;
    reg  [31:0] fast_route_state;
    reg  [31:0] spurious_handler_address;
    reg  [1:0]  control;
    reg  [31:0] src_vector [0:`VIC_NUM_SRC-1];
    reg         in_service;
    reg  [4:0]  current_id;
    reg         cand_lat;       // candidate latched at first access cycle
    reg  [4:0]  cand_id_lat;
    reg         fast_lat;

    wire        protection_mode_bit = control[`VIC_PROTECTION_MODE_BIT_BIT];
    wire        global_mask_bit     = control[`VIC_GMASK_BIT];

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // access phase first cycle prepares data, second completes
    wire        acc_first = psel & penable & ~pready;
    wire        done      = psel & penable & pready;
    wire        wr        = done & pwrite;
    wire        rd        = done & ~pwrite;
    wire [31:0] wr_data   = wr ? pwdata : 32'h0000_0000;

    wire        hit_clr   = (paddr == `VIC_CLEAR_COMMAND);
    wire        hit_set   = (paddr == `VIC_SET_COMMAND);
    wire        hit_eoi   = (paddr == `VIC_EOI_COMMAND);
    wire        hit_ivr   = (paddr == `VIC_NORMAL_VECTOR);
    wire        hit_fvr   = (paddr == `VIC_FAST_VECTOR);
    wire        hit_svr   = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);

    // ----------------------------------------------------------------
    // prioritisation
    // ----------------------------------------------------------------
    wire [31:0] active      = pending & enable_state;
    // forced sources leave the normal path
    wire [31:0] normal_cand = active & ~fast_route_state & 32'hffff_fffe;
    wire        fast_any    = active[`VIC_FAST_SRC] | (|(active & fast_route_state));
    reg  [4:0]  cand_id;
    integer     i;

    // lowest index wins; loop runs high to low so the last hit stands
    always @*
    begin
        cand_id = 5'h00;
        for (i = 31; i >= 1; i = i - 1)
        begin
            if (normal_cand[i])
            begin
                cand_id = i[4:0];
            end
        end
    end

    wire        cand_any = |normal_cand;

    // acknowledge: normal vector read in normal mode, write in protection mode; fast vector always by read
    wire        ivr_ack  = done & hit_ivr & (protection_mode_bit ? pwrite : ~pwrite);
    wire        take_irq = ivr_ack & cand_lat & ~in_service;
    wire        fvr_ack  = rd & hit_fvr & fast_lat;

    // ----------------------------------------------------------------
    // source synchroniser and edge detect
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_meta <= 32'h0000_0000;
            src_sync <= 32'h0000_0000;
            src_prev <= 32'h0000_0000;
        end
        else
        begin
            src_meta <= source_in;
            src_sync <= src_meta;
            src_prev <= src_sync;
        end
    end

    wire [31:0] src_edge = src_sync & ~src_prev;

    // ----------------------------------------------------------------
    // pending bits, one per source
    // ----------------------------------------------------------------
    // set terms win over clear in the same cycle so no event is lost
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1)
        begin : g_pend
            wire set_bit = src_edge[g] | (hit_set & wr_data[g]);
            wire clr_bit = (hit_clr & wr_data[g])
                         | (take_irq & (cand_id_lat == g))
                         | (fvr_ack & (g == `VIC_FAST_SRC));
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pending[g] <= 1'b0;
                end
                else if (set_bit)
                begin
                    pending[g] <= 1'b1;
                end
                else if (clr_bit)
                begin
                    pending[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_state             <= 32'h0000_0000;
            fast_route_state         <= 32'h0000_0000;
            spurious_handler_address <= `VIC_SPURIOUS_RESET;
            control                  <= `VIC_CONTROL_RESET;
        end
        else
        begin
            if (paddr == `VIC_ENABLE_COMMAND)
            begin
                enable_state <= enable_state | wr_data;
            end
            else if (paddr == `VIC_DISABLE_COMMAND)
            begin
                enable_state <= enable_state & ~wr_data;
            end
            // bit 0 is never stored, fast source needs no forcing
            if (paddr == `VIC_FAST_ROUTE_ENABLE)
            begin
                fast_route_state <= (fast_route_state | wr_data) & 32'hffff_fffe;
            end
            else if (paddr == `VIC_FAST_ROUTE_DISABLE)
            begin
                fast_route_state <= fast_route_state & ~wr_data & 32'hffff_fffe;
            end
            if (wr && paddr == `VIC_SPURIOUS_VECTOR)
            begin
                spurious_handler_address <= pwdata;
            end
            if (wr && paddr == `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL)
            begin
                control <= pwdata[1:0];
            end
        end
    end

    // vector array, no reset: contents are software's business
    always @(posedge pclk)
    begin
        if (wr && hit_svr)
        begin
            src_vector[paddr[6:2]] <= pwdata;
        end
    end

    // ----------------------------------------------------------------
    // current interrupt tracking
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_service  <= 1'b0;
            current_id  <= 5'h00;
            cand_lat    <= 1'b0;
            cand_id_lat <= 5'h00;
            fast_lat    <= 1'b0;
        end
        else
        begin
            // latch with read data so ack matches the value returned
            if (acc_first)
            begin
                cand_lat    <= cand_any & ~in_service;
                cand_id_lat <= cand_id;
                fast_lat    <= active[`VIC_FAST_SRC];
            end
            if (wr && hit_eoi)
            begin
                in_service <= 1'b0;
            end
            else if (take_irq)
            begin
                in_service <= 1'b1;
                current_id <= cand_id_lat;
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    reg  [31:0] next_prdata;
    reg         next_err;

    always @*
    begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        if (hit_svr)
        begin
            next_prdata = pwrite ? 32'h0000_0000 : src_vector[paddr[6:2]];
        end
        else
        begin
            case (paddr)
                `VIC_NORMAL_VECTOR:
                    next_prdata = (cand_any & ~in_service) ? src_vector[cand_id]
                                                           : spurious_handler_address;
                `VIC_FAST_VECTOR:
                    next_prdata = active[`VIC_FAST_SRC] ? src_vector[`VIC_FAST_SRC]
                                                        : spurious_handler_address;
                `VIC_CURRENT_ID:         next_prdata = {27'h0, current_id};
                `VIC_PENDING:            next_prdata = pending;
                `VIC_ENABLE_STATE:       next_prdata = enable_state;
                `VIC_SPURIOUS_VECTOR:    next_prdata = spurious_handler_address;
                `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL: next_prdata = {30'h0, control};
                `VIC_FAST_ROUTE_STATE:   next_prdata = fast_route_state;
                `VIC_ENABLE_COMMAND, `VIC_DISABLE_COMMAND, `VIC_CLEAR_COMMAND,
                `VIC_SET_COMMAND, `VIC_EOI_COMMAND, `VIC_FAST_ROUTE_ENABLE,
                `VIC_FAST_ROUTE_DISABLE:
                    next_prdata = 32'h0000_0000;
                default:
                    next_err = 1'b1;
            endcase
        end
    end

    // one wait state: registered data and ready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (acc_first)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pready  <= 1'b1;
            pslverr <= next_err;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // request outputs
    // ----------------------------------------------------------------
    // registered so the core sees glitch-free lines; one cycle of lag
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            normal_request_output_n <= 1'b1;
            fast_request_output_n   <= 1'b1;
        end
        else if (global_mask_bit)
        begin
            normal_request_output_n <= 1'b1;
            fast_request_output_n   <= 1'b1;
        end
        else
        begin
            normal_request_output_n <= ~(cand_any & ~in_service);
            fast_request_output_n   <= ~fast_any;
        end
    end

endmodule // vic_cmd_regs

`default_nettype wire

// ===== core/vic_regs.vh
// Purpose: register map and field constants of the interrupt command block
// Assumes: 32-bit APB, byte addresses, each register one aligned word
// Notes:   vector array occupies the first 32 words
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VIC_SRC_VECTOR_BASE      12'h000
`define VIC_NORMAL_VECTOR        12'h100
`define VIC_FAST_VECTOR          12'h104
`define VIC_CURRENT_ID           12'h108
`define VIC_PENDING              12'h10c
`define VIC_ENABLE_STATE         12'h110
`define VIC_ENABLE_COMMAND       12'h120
`define VIC_DISABLE_COMMAND      12'h124
`define VIC_CLEAR_COMMAND        12'h128
`define VIC_SET_COMMAND          12'h12c
`define VIC_EOI_COMMAND          12'h130
`define VIC_SPURIOUS_VECTOR      12'h134
`define VIC_PROTECTION_MODE_BIT_GMASK_CONTROL   12'h138
`define VIC_FAST_ROUTE_ENABLE    12'h140
`define VIC_FAST_ROUTE_DISABLE   12'h144
`define VIC_FAST_ROUTE_STATE     12'h148

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define VIC_PROTECTION_MODE_BIT_BIT             0
`define VIC_GMASK_BIT            1
`define VIC_FAST_SRC             0
`define VIC_SPURIOUS_RESET       32'h0000_0000
`define VIC_CONTROL_RESET        2'h0
`define VIC_NUM_SRC              32

`endif

// ===== verif/tb.sv
// Purpose: self-checking bench of the interrupt command block
// Assumes: apb master per the hand-over contract, 40 MHz pclk
// Notes:   bus results go through a queue to a monitor process
`timescale 1ns/100ps
`include "vic_regs.vh"
`default_nettype none
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_seen, fiq_seen;
    logic        normal_request_output_n, fast_request_output_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, source_in, v, m;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    integer      error_cnt = 0, num_checks = 0, seed = 10, cycles = 0, i;
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;
    vic_cmd_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .source_in(source_in), .normal_request_output_n(normal_request_output_n),
        .fast_request_output_n(fast_request_output_n));
    vic_core_model u_core (.pclk(pclk), .presetn(presetn), .normal_request_output_n(normal_request_output_n),
        .fast_request_output_n(fast_request_output_n), .irq_seen(irq_seen), .fiq_seen(fiq_seen));
    task check_bus(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t bus got %h exp %h", $time, got, exp);
        end
    endtask
    // core view lags the line by one register stage
    task check_lines(input logic irq, input logic fast_source_bit);
        repeat (3) @(posedge pclk);
        #1;
        num_checks++;
        if ({irq_seen, fiq_seen} !== {irq, fast_source_bit})
        begin
            error_cnt++;
            $display("CHECK FAILED %0t lines %b%b exp %b%b", $time, irq_seen, fiq_seen, irq, fast_source_bit);
        end
    endtask
    // one transfer; e holds {pslverr, read data} expected
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        exp_q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task finish_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // monitor: each completion takes the oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
        begin
            e = exp_q.pop_front();
            check_bus(pwrite ? {pslverr, e[31:0]} : {pslverr, prdata}, e);
        end
    // hang guard, well above the sequence length
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            finish_test;
        end
    end
    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        source_in = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `VIC_SPURIOUS_VECTOR, 0, 33'h0);
        apb(0, `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL, 0, 33'h0);
        apb(0, `VIC_FAST_ROUTE_STATE, 0, 33'h0);
        apb(0, 12'h080, 0, {1'b1, 32'h0});
        apb(1, 12'h13c, 32'hffff_ffff, {1'b1, 32'h0});
        v = $random(seed);
        apb(1, `VIC_SPURIOUS_VECTOR, v, 33'h0);
        apb(0, `VIC_SPURIOUS_VECTOR, 0, {1'b0, v});
        apb(0, `VIC_NORMAL_VECTOR, 0, {1'b0, v});
        apb(0, `VIC_FAST_VECTOR, 0, {1'b0, v});
        // set and clear with random masks, sources all disabled
        for (i = 0; i < 4; i++)
        begin
            v = $random(seed);
            m = $random(seed);
            apb(1, `VIC_SET_COMMAND, v, 33'h0);
            apb(0, `VIC_PENDING, 0, {1'b0, v});
            apb(1, `VIC_CLEAR_COMMAND, m, 33'h0);
            apb(0, `VIC_PENDING, 0, {1'b0, v & ~m});
            apb(1, `VIC_CLEAR_COMMAND, 32'hffff_ffff, 33'h0);
        end
        apb(1, `VIC_FAST_ROUTE_ENABLE, 32'hffff_ffff, 33'h0);
        apb(0, `VIC_FAST_ROUTE_STATE, 0, {1'b0, 32'hffff_fffe});
        m = $random(seed);
        apb(1, `VIC_FAST_ROUTE_DISABLE, m, 33'h0);
        apb(0, `VIC_FAST_ROUTE_STATE, 0, {1'b0, 32'hffff_fffe & ~m});
        apb(1, `VIC_FAST_ROUTE_DISABLE, 32'hffff_ffff, 33'h0);
        // random rising edges on the source pins
        v = $random(seed);
        @(posedge pclk) source_in <= v;
        repeat (5) @(posedge pclk);
        apb(0, `VIC_PENDING, 0, {1'b0, v});
        source_in <= 32'h0;
        apb(1, `VIC_CLEAR_COMMAND, 32'hffff_ffff, 33'h0);
        // request lines with sources 0 and 5 enabled
        v = $random(seed);
        m = $random(seed);
        apb(1, 12'h014, v, 33'h0);
        apb(1, 12'h000, m, 33'h0);
        apb(1, `VIC_ENABLE_COMMAND, 32'h21, 33'h0);
        apb(1, `VIC_SET_COMMAND, 32'h20, 33'h0);
        check_lines(1, 0);
        apb(1, `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL, 32'h2, 33'h0);
        check_lines(0, 0);
        apb(1, `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL, 32'h1, 33'h0);
        check_lines(1, 0);
        apb(0, `VIC_NORMAL_VECTOR, 0, {1'b0, v});
        apb(0, `VIC_PENDING, 0, {1'b0, 32'h20});
        apb(1, `VIC_NORMAL_VECTOR, 0, 33'h0);
        apb(0, `VIC_PENDING, 0, 33'h0);
        check_lines(0, 0);
        apb(1, `VIC_EOI_COMMAND, $random(seed), 33'h0);
        apb(1, `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL, 0, 33'h0);
        apb(1, `VIC_SET_COMMAND, 32'h20, 33'h0);
        check_lines(1, 0);
        apb(1, `VIC_FAST_ROUTE_ENABLE, 32'h20, 33'h0);
        check_lines(0, 1);
        apb(1, `VIC_SET_COMMAND, 32'h1, 33'h0);
        apb(0, `VIC_FAST_VECTOR, 0, {1'b0, m});
        apb(0, `VIC_PENDING, 0, {1'b0, 32'h20});
        apb(1, `VIC_CLEAR_COMMAND, 32'h20, 33'h0);
        check_lines(0, 0);
        // unprotected acknowledge: the read itself takes the interrupt
        apb(1, `VIC_FAST_ROUTE_DISABLE, 32'h20, 33'h0);
        apb(1, `VIC_SET_COMMAND, 32'h20, 33'h0);
        apb(0, `VIC_NORMAL_VECTOR, 0, {1'b0, v});
        apb(0, `VIC_PENDING, 0, 33'h0);
        check_lines(0, 0);
        apb(1, `VIC_EOI_COMMAND, 0, 33'h0);
        check_lines(0, 0);
        finish_test;
    end
endmodule // tb
`default_nettype wire

// ===== verif/vic_cmd_regs_asserts.sv
// Purpose: port-level checks of the interrupt command block
// Assumes: one pclk domain, presetn async active low
// Notes:   shadows only registers whose content shows on the bus
`timescale 1ns/100ps
`include "vic_regs.vh"
`default_nettype none
module vic_cmd_regs_asserts
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // sources and request lines
    input  wire logic [31:0] source_in,
    input  wire logic        normal_request_output_n,
    input  wire logic        fast_request_output_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] spur;
    logic [1:0]  ctl;
    logic [31:0] frc;
    logic        done;
    assign done = psel && penable && pready;
    // shadows move only at a completed write; refused cycles change nothing
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            spur <= 32'h0;
            ctl  <= 2'h0;
            frc  <= 32'h0;
        end
        else if (done && pwrite)
        begin
            if (paddr == `VIC_SPURIOUS_VECTOR) spur <= pwdata;
            if (paddr == `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL) ctl <= pwdata[1:0];
            if (paddr == `VIC_FAST_ROUTE_ENABLE) frc <= frc | (pwdata & 32'hffff_fffe);
            if (paddr == `VIC_FAST_ROUTE_DISABLE) frc <= frc & ~pwdata;
        end
    function automatic logic mapped(input logic [11:0] a);
        // unaligned offsets are refused like holes in the map
        mapped = (a[1:0] == 2'h0)
                 && ((a < 12'h080) || (a >= 12'h100 && a <= 12'h110) || (a >= 12'h120 && a <= 12'h138)
                     || (a >= 12'h140 && a <= 12'h148));
    endfunction
    // apb phases
    sequence s_setup;  psel && !penable; endsequence
    sequence s_access; psel && penable;  endsequence
    a_ready_in_time: assert property (s_setup ##1 s_access |=> pready) else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
    a_error_unmapped: assert property (done |-> pslverr == !mapped(paddr)) else $error("pslverr wrong");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_spurious_read: assert property (done && !pwrite && paddr == `VIC_SPURIOUS_VECTOR |-> prdata == spur)
        else $error("spurious readback");
    a_control_read: assert property (done && !pwrite && paddr == `VIC_PROTECTION_MODE_BIT_GMASK_CONTROL
        |-> prdata == {30'h0, ctl}) else $error("control readback");
    a_force_state: assert property (done && !pwrite && paddr == `VIC_FAST_ROUTE_STATE
        |-> prdata == frc) else $error("fast route state");
    a_mask_idle_lines: assert property (ctl[1] |=> normal_request_output_n && fast_request_output_n)
        else $error("masked line active");
endmodule // vic_cmd_regs_asserts
bind vic_cmd_regs vic_cmd_regs_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .source_in(source_in), .normal_request_output_n(normal_request_output_n),
    .fast_request_output_n(fast_request_output_n));
`default_nettype wire

// ===== verif/vic_core_model.sv
// Purpose: processor core input stage seen by the request lines
// Assumes: core samples both active-low lines on pclk
// Notes:   one register stage, so the bench allows one extra cycle
`timescale 1ns/100ps
`default_nettype none
module vic_core_model
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // request lines, active low
    input  wire logic normal_request_output_n,
    input  wire logic fast_request_output_n,
    // requests as taken in by the core
    output var  logic irq_seen,
    output var  logic fiq_seen
);
    // a real core registers its inputs; no combinational view
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            irq_seen <= 1'b0;
            fiq_seen <= 1'b0;
        end
        else
        begin
            irq_seen <= !normal_request_output_n;
            fiq_seen <= !fast_request_output_n;
        end
endmodule // vic_core_model
`default_nettype wire
